/* pkg/mfp_pkg.sv */
// package for the fifo partition and ecc status block
// assumes one 40 MHz clock shared by both ends of the register link
package mfp_pkg;
    // ==========================================================
    // register indices on the link (one 32-bit word each)
    localparam logic [6:0] REG_CLEAR = 7'h36;
    localparam logic [6:0] REG_INJ = 7'h3D;
    localparam logic [6:0] REG_SIZE = 7'h3E;
    localparam logic [6:0] REG_TFC = 7'h3F;
    localparam logic [6:0] REG_TXFILL = 7'h40;
    localparam logic [6:0] REG_OVF = 7'h41;
    localparam logic [6:0] REG_ECCADDR = 7'h42;
    localparam logic [6:0] REG_CECC0 = 7'h43;
    localparam logic [6:0] REG_CECC_LAST = 7'h49;
    localparam logic [6:0] REG_IRQ_STAT = 7'h4A;
    localparam logic [6:0] REG_IRQ_MASK = 7'h4B;
    // ==========================================================
    // fields and reset values
    localparam int HI_LSB = 8;
    localparam int LO_LSB = 4;
    localparam int HTX_LSB = 0;
    localparam int CLR_TX_BIT = 1;
    localparam int CLR_RX_BIT = 0;
    localparam logic [11:0] SIZE_RESET = 12'h464;
    localparam logic [3:0] SIZE_MAX_CODE = 4'h8;
    localparam logic [4:0] TOTAL_STEPS = 5'h0E;
    localparam logic [13:0] HALFWORDS_PER_STEP = 14'h0400;
    localparam int CECC_NUM = 7;
    localparam logic [2:0] CECC_RX_LO = 3'h0;
    localparam logic [2:0] CECC_RX_HI = 3'h1;
    localparam logic [2:0] CECC_HTX = 3'h4;
    // interrupt status bits
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_ECC_BIT = 1;
    // ==========================================================
    // host controller software registers
    localparam logic [1:0] HREG_CTRL = 2'h0;
    localparam logic [1:0] HREG_STAT = 2'h1;
    localparam logic [1:0] HREG_RADDR = 2'h2;
    localparam logic [1:0] HREG_RDATA = 2'h3;
    localparam int CTRL_GO_BIT = 16;
    localparam int RADDR_RD_BIT = 8;
    localparam int RADDR_WR_BIT = 9;
endpackage

/* pkg/mfp_link_if.sv */
// register link between the host controller and the device end
// assumes a single shared clock; read data return one cycle after rd
`timescale 1ns/10ps
`default_nettype none
interface mfp_link_if;
    logic [6:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

/* src/mfp_device.sv */
// device end: fifo size config, tx fill tracking, overflow and ecc status
// assumes the link master keeps strobes one cycle and never both at once
//
// Summary of operation
// RULE1 - host halts traffic, fifos empty before resize
// RULE2 - host discards all frames before resize
// RULE3 - host clears fifos, then writes sizes
// RULE4 - host keeps total allocation within 28 kB
// RULE5 - high rx size bits 11:8, reset 4
// RULE6 - low rx size bits 7:4, reset 6
// RULE7 - tx size bits 3:0, reset 4
// RULE8 - read-only 9-bit tx frame count
// RULE9 - read-only 14-bit tx half-word fill
// RULE10 - 32-bit count of overflow-dropped tx frames
// RULE11 - record 14-bit ecc fault address
// RULE12 - 10-bit corrected error counter per fifo
// RULE13 - index 0 low, 1 high, 4 tx
// RULE14 - tx flush mid-frame aborts with bad fcs
// RULE15 - rx resumes storing at next frame start
// RULE16 - no high-queue routing when high size zero
// RULE17 - size codes above 16 kB are reserved
`timescale 1ns/10ps
`default_nettype none
module mfp_device
    import mfp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    mfp_link_if.dev link,
    input wire logic tx_push_i,
    input wire logic tx_push_last_i,
    input wire logic tx_pop_i,
    input wire logic tx_pop_last_i,
    input wire logic tx_busy_i,
    input wire logic rx_frame_start_i,
    input wire logic ecc_det_i,
    input wire logic [13:0] ecc_addr_i,
    input wire logic ecc_corr_i,
    input wire logic [2:0] ecc_fifo_i,
    output logic [3:0] rx_high_queue_size_o,
    output logic [3:0] rx_low_queue_size_o,
    output logic [3:0] host_transmit_queue_size_o,
    output logic rx_store_en_o,
    output logic tx_abort_bad_fcs_o,
    output logic irq_o
);
    // ==========================================================
    // configuration registers
    logic [11:0] size_cfg;
    logic inj;
    logic [1:0] irq_mask;
    logic [1:0] irq_stat;
    logic wr_clr;
    logic flush_tx;
    logic flush_rx;
    logic [13:0] tx_cap;
    logic [3:0] htx_code;

    assign wr_clr = link.wr && (link.addr == REG_CLEAR);
    assign flush_tx = wr_clr && link.wdata[CLR_TX_BIT];
    assign flush_rx = wr_clr && link.wdata[CLR_RX_BIT];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            size_cfg <= SIZE_RESET; // see RULE5 see RULE6 see RULE7
            inj <= 1'b0;
            irq_mask <= 2'h0;
        end else if (link.wr) begin
            case (link.addr)
                REG_SIZE: size_cfg <= link.wdata[11:0];
                REG_INJ: inj <= link.wdata[0];
                REG_IRQ_MASK: irq_mask <= link.wdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_high_queue_size_o <= SIZE_RESET[HI_LSB +: 4];
            rx_low_queue_size_o <= SIZE_RESET[LO_LSB +: 4];
            host_transmit_queue_size_o <= SIZE_RESET[HTX_LSB +: 4];
        end else begin
            rx_high_queue_size_o <= size_cfg[HI_LSB +: 4]; // see RULE5
            rx_low_queue_size_o <= size_cfg[LO_LSB +: 4]; // see RULE6
            host_transmit_queue_size_o <= size_cfg[HTX_LSB +: 4]; // see RULE7
        end
    end

    // a reserved tx size code is clamped so tx capacity never exceeds 16 kB; rx codes pass through unclamped
    assign htx_code = (size_cfg[HTX_LSB +: 4] > SIZE_MAX_CODE) ? SIZE_MAX_CODE : size_cfg[HTX_LSB +: 4]; // see RULE17
    assign tx_cap = 14'(htx_code * HALFWORDS_PER_STEP);

    // ==========================================================
    // host transmit fifo occupancy
    logic [13:0] tx_fill;
    logic [8:0] tx_frames;
    logic [31:0] ovf_drops;
    logic dropping;
    logic room;
    logic push_ok;

    assign room = tx_fill < tx_cap;
    assign push_ok = tx_push_i && !dropping && room;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_fill <= 14'h0000;
        end else if (flush_tx) begin
            tx_fill <= 14'h0000;
        end else begin
            tx_fill <= tx_fill + 14'(push_ok) - 14'(tx_pop_i && tx_fill != 14'h0000); // see RULE9
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_frames <= 9'h000;
        end else if (flush_tx) begin
            tx_frames <= 9'h000;
        end else begin
            tx_frames <= tx_frames + 9'(tx_push_i && tx_push_last_i && !dropping && room)
                - 9'(tx_pop_last_i && tx_frames != 9'h000); // see RULE8
        end
    end

    // a frame that meets a full fifo is dropped whole and counted at its end;
    // words already accepted stay, which is a known limitation of this model
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dropping <= 1'b0;
        end else if (tx_push_i && tx_push_last_i) begin
            dropping <= 1'b0;
        end else if (tx_push_i && !room) begin
            dropping <= 1'b1;
        end
    end

    logic ovf_event;
    assign ovf_event = tx_push_i && tx_push_last_i && (dropping || !room);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovf_drops <= 32'h0000_0000;
        end else if (ovf_event) begin
            ovf_drops <= ovf_drops + 32'h0000_0001; // see RULE10
        end
    end

    // flushing mid-frame stops the frame and forces a bad check sequence
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_abort_bad_fcs_o <= 1'b0;
        end else begin
            tx_abort_bad_fcs_o <= flush_tx && tx_busy_i; // see RULE14
        end
    end

    // ==========================================================
    // receive side resume after flush
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_store_en_o <= 1'b1;
        end else if (flush_rx) begin
            rx_store_en_o <= 1'b0;
        end else if (rx_frame_start_i) begin
            rx_store_en_o <= 1'b1; // see RULE15
        end
    end

    // ==========================================================
    // ecc status
    logic [13:0] ecc_addr;
    logic [9:0] cecc [CECC_NUM];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ecc_addr <= 14'h0000;
        end else if (ecc_det_i) begin
            ecc_addr <= ecc_addr_i; // see RULE11
        end
    end

    // counters saturate rather than wrap so a burst is never hidden
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < CECC_NUM; i++) begin
                cecc[i] <= 10'h000;
            end
        end else if (ecc_corr_i && int'(ecc_fifo_i) < CECC_NUM && cecc[ecc_fifo_i] != 10'h3FF) begin
            // index 0 low rx, 1 high rx, 4 host tx; see RULE12 see RULE13
            cecc[ecc_fifo_i] <= cecc[ecc_fifo_i] + 10'h001;
        end
    end

    // ==========================================================
    // interrupts: set wins over a write-one clear in the same cycle
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    assign irq_set = {ecc_det_i, ovf_event};
    assign irq_clr = (link.wr && link.addr == REG_IRQ_STAT) ? link.wdata[1:0] : 2'h0;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_stat <= 2'h0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((irq_stat & ~irq_clr) | irq_set) & ~irq_mask);
        end
    end

    // ==========================================================
    // read data, one cycle after the strobe; unmapped reads return zero
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (link.addr >= REG_CECC0 && link.addr <= REG_CECC_LAST) begin
            next_rdata = {22'h000000, cecc[3'(link.addr - REG_CECC0)]}; // see RULE12
        end else begin
            case (link.addr)
                REG_INJ: next_rdata = {31'h0000_0000, inj};
                REG_SIZE: next_rdata = {20'h00000, size_cfg};
                REG_TFC: next_rdata = {23'h000000, tx_frames}; // see RULE8
                REG_TXFILL: next_rdata = {18'h00000, tx_fill}; // see RULE9
                REG_OVF: next_rdata = ovf_drops; // see RULE10
                REG_ECCADDR: next_rdata = {18'h00000, ecc_addr}; // see RULE11
                REG_IRQ_STAT: next_rdata = {30'h0000_0000, irq_stat};
                REG_IRQ_MASK: next_rdata = {30'h0000_0000, irq_mask};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link.rdata <= 32'h0000_0000;
        end else if (link.rd) begin
            link.rdata <= next_rdata;
        end else begin
            link.rdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

/* src/mfp_host.sv */
// host end: runs the safe resize sequence and passes software accesses
// assumes the device answers link reads one cycle after rd
`timescale 1ns/10ps
`default_nettype none
module mfp_host
    import mfp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    mfp_link_if.host link,
    input wire logic [1:0] sw_addr_i,
    input wire logic [31:0] sw_wdata_i,
    input wire logic sw_wr_i,
    input wire logic sw_rd_i,
    output logic [31:0] sw_rdata_o,
    output logic traffic_halt_o,
    output logic forward_discard_o,
    output logic unknown_dest_forward_o,
    output logic high_queue_allowed_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RD_TFC = 3'b001,
        ST_EV_TFC = 3'b010,
        ST_RD_FILL = 3'b011,
        ST_EV_FILL = 3'b100,
        ST_CLR = 3'b101,
        ST_SIZE = 3'b110
    } mfp_hstate_t;

    mfp_hstate_t state;
    logic [11:0] new_size;
    logic err;
    logic done;
    logic [31:0] rbuf;
    logic rd_pend;
    logic go;
    logic fits;

    assign go = sw_wr_i && sw_addr_i == HREG_CTRL && sw_wdata_i[CTRL_GO_BIT];
    // each field within 16 kB and the sum within the buffer
    assign fits = sw_wdata_i[11:8] <= SIZE_MAX_CODE && sw_wdata_i[7:4] <= SIZE_MAX_CODE
        && sw_wdata_i[3:0] <= SIZE_MAX_CODE
        && (5'(sw_wdata_i[11:8]) + 5'(sw_wdata_i[7:4]) + 5'(sw_wdata_i[3:0])) <= TOTAL_STEPS; // see RULE4

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            new_size <= SIZE_RESET;
            err <= 1'b0;
            done <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (go && fits) begin
                        new_size <= sw_wdata_i[11:0];
                        err <= 1'b0;
                        done <= 1'b0;
                        state <= ST_RD_TFC;
                    end else if (go) begin
                        err <= 1'b1;
                    end
                end
                ST_RD_TFC: state <= ST_EV_TFC;
                // wait until the transmit fifo holds nothing; see RULE1
                ST_EV_TFC: if (rd_pend) state <= (link.rdata == 32'h0000_0000) ? ST_RD_FILL : ST_RD_TFC;
                ST_RD_FILL: state <= ST_EV_FILL;
                ST_EV_FILL: if (rd_pend) state <= (link.rdata == 32'h0000_0000) ? ST_CLR : ST_RD_FILL;
                ST_CLR: state <= ST_SIZE; // see RULE3
                ST_SIZE: begin
                    done <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // link drive: sequence owns the link, otherwise software passes through
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link.addr <= 7'h00;
            link.wdata <= 32'h0000_0000;
            link.wr <= 1'b0;
            link.rd <= 1'b0;
        end else begin
            link.wr <= 1'b0;
            link.rd <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (!go && sw_wr_i && sw_addr_i == HREG_RADDR) begin
                        link.addr <= sw_wdata_i[6:0];
                        link.rd <= sw_wdata_i[RADDR_RD_BIT];
                        link.wr <= sw_wdata_i[RADDR_WR_BIT] && !sw_wdata_i[RADDR_RD_BIT];
                    end
                    if (!go && sw_wr_i && sw_addr_i == HREG_RDATA) begin
                        link.wdata <= sw_wdata_i;
                    end
                end
                ST_RD_TFC: begin
                    link.addr <= REG_TFC;
                    link.rd <= 1'b1;
                end
                ST_RD_FILL: begin
                    link.addr <= REG_TXFILL;
                    link.rd <= 1'b1;
                end
                ST_CLR: begin
                    link.addr <= REG_CLEAR;
                    link.wdata <= 32'h0000_0003; // see RULE3
                    link.wr <= 1'b1;
                end
                ST_SIZE: begin
                    link.addr <= REG_SIZE;
                    link.wdata <= {20'h00000, new_size}; // see RULE3
                    link.wr <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    // rd_pend marks the cycle the answer stands, for passthrough and the waits
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_pend <= 1'b0;
            rbuf <= 32'h0000_0000;
        end else begin
            rd_pend <= link.rd;
            if (rd_pend && state == ST_IDLE) begin
                rbuf <= link.rdata;
            end
        end
    end

    // ==========================================================
    // traffic control levels held for the whole sequence
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            traffic_halt_o <= 1'b0;
            forward_discard_o <= 1'b0;
            unknown_dest_forward_o <= 1'b1;
            high_queue_allowed_o <= 1'b1;
        end else begin
            traffic_halt_o <= (state != ST_IDLE) || (go && fits); // see RULE1
            forward_discard_o <= (state != ST_IDLE) || (go && fits); // see RULE2
            unknown_dest_forward_o <= (state == ST_IDLE) && !(go && fits); // see RULE2
            high_queue_allowed_o <= new_size[HI_LSB +: 4] != 4'h0; // see RULE16
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_rdata_o <= 32'h0000_0000;
        end else if (sw_rd_i) begin
            case (sw_addr_i)
                HREG_CTRL: sw_rdata_o <= {20'h00000, new_size};
                HREG_STAT: sw_rdata_o <= {29'h0000_0000, done, err, state != ST_IDLE};
                HREG_RDATA: sw_rdata_o <= rbuf;
                default: sw_rdata_o <= {25'h0000000, link.addr};
            endcase
        end else begin
            sw_rdata_o <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

/* test/mfp_chk.sv */
// checker on the register link between the host end and the device end
// assumes one shared clock; sees only the link signals as plain inputs
`timescale 1ns/10ps
`default_nettype none
module mfp_chk
    import mfp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [6:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata
);
    // ==========================================================
    // shadow of the size word, built from link writes only
    logic [11:0] size_sh;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            size_sh <= SIZE_RESET;
        end else if (wr && addr == REG_SIZE) begin
            size_sh <= wdata[11:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // assertions
    chk_size_high: assert property (rd && addr == REG_SIZE |=> rdata[11:8] == size_sh[11:8])
        else $error("high rx size field reads wrong");
    chk_size_low: assert property (rd && addr == REG_SIZE |=> rdata[7:4] == size_sh[7:4])
        else $error("low rx size field reads wrong");
    chk_size_tx: assert property (rd && addr == REG_SIZE |=> rdata[3:0] == size_sh[3:0])
        else $error("tx size field reads wrong");
    chk_frames_width: assert property (rd && addr == REG_TFC |=> rdata[31:9] == 23'h0)
        else $error("frame count wider than 9 bits");
    chk_fill_width: assert property (rd && addr == REG_TXFILL ##1 1'b1 |-> rdata[31:14] == 18'h0)
        else $error("fill count wider than 14 bits");
    chk_fault_width: assert property (rd && addr == REG_ECCADDR |=> $past(addr) == REG_ECCADDR && rdata[31:14] == 18'h0)
        else $error("fault address wider than 14 bits");
    chk_tally_width: assert property (rd && addr >= REG_CECC0 && addr <= REG_CECC_LAST |=> rdata[31:10] == 22'h0)
        else $error("corrected tally wider than 10 bits");
    // sizes change only right after both queues were flushed
    chk_flush_first: assert property (wr && addr == REG_SIZE |-> $past(wr) && $past(addr) == REG_CLEAR && $past(wdata[1:0]) == 2'h3)
        else $error("size write without preceding flush");
    cov_resize: cover property (wr && addr == REG_SIZE);
    cov_fill_read: cover property (rd && addr == REG_TXFILL ##1 rdata != 32'h0);
    cov_tx_flush: cover property (wr && addr == REG_CLEAR && wdata[CLR_TX_BIT]);
endmodule
`default_nettype wire

/* test/test_mac_fifo_partition_and_ecc_status.sv */
// testbench: host end and device end joined by the link interface
// assumes one 40 MHz clock; the bench plays software and the mac datapath
`timescale 1ns/10ps
`default_nettype none
module test_mac_fifo_partition_and_ecc_status;
    import mfp_pkg::*;
    // ==========================================================
    // signals
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] sw_addr = 2'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0, sw_rd = 1'b0, rd_d = 1'b0;
    logic push = 1'b0, push_last = 1'b0, pop = 1'b0, pop_last = 1'b0, busy = 1'b0, rx_start = 1'b0;
    logic ecc_det = 1'b0, ecc_corr = 1'b0;
    logic [13:0] ecc_addr = 14'h0;
    logic [2:0] ecc_fifo = 3'h0;
    logic [31:0] sw_rdata, seed = 32'h083B;
    logic halt, discard, unk, hi_ok, store_en, abort, irq;
    logic [3:0] hi_sz, lo_sz, htx_sz;
    logic [31:0] exp_q[$];
    int failures = 0, n_tests = 0, aborts = 0;
    logic [11:0] bad[2] = '{12'h900, 12'h666};
    mfp_link_if link_if ();
    mfp_host mfp_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if.host), .sw_addr_i(sw_addr),
        .sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata), .traffic_halt_o(halt),
        .forward_discard_o(discard), .unknown_dest_forward_o(unk), .high_queue_allowed_o(hi_ok));
    mfp_device mfp_device_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_if.dev), .tx_push_i(push),
        .tx_push_last_i(push_last), .tx_pop_i(pop), .tx_pop_last_i(pop_last), .tx_busy_i(busy),
        .rx_frame_start_i(rx_start), .ecc_det_i(ecc_det), .ecc_addr_i(ecc_addr), .ecc_corr_i(ecc_corr),
        .ecc_fifo_i(ecc_fifo), .rx_high_queue_size_o(hi_sz), .rx_low_queue_size_o(lo_sz),
        .host_transmit_queue_size_o(htx_sz), .rx_store_en_o(store_en), .tx_abort_bad_fcs_o(abort), .irq_o(irq));
    mfp_chk mfp_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr(link_if.addr), .wdata(link_if.wdata),
        .wr(link_if.wr), .rd(link_if.rd), .rdata(link_if.rdata));
    initial forever #12.5 clk_i = ~clk_i;
    // ==========================================================
    // checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // read data stand only in the cycle after the strobe, so the note is taken there
    always @(posedge clk_i) begin
        rd_d <= sw_rd;
        if (rd_d) check(sw_rdata, exp_q.pop_front());
        if (abort === 1'b1) aborts++;
        if (halt === 1'b1) begin
            check({31'h0, discard}, 32'h1);
            check({31'h0, unk}, 32'h0);
        end
    end
    // ==========================================================
    // software port and datapath tasks
    task automatic sw_wr_t(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk_i);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk_i);
        sw_wr <= 1'b0;
    endtask
    task automatic dev_rd(input logic [6:0] idx, input logic [31:0] want);
        sw_wr_t(HREG_RADDR, (32'h1 << RADDR_RD_BIT) | {25'h0, idx});
        repeat (5) @(posedge clk_i);
        exp_q.push_back(want);
        @(posedge clk_i);
        sw_addr <= HREG_RDATA;
        sw_rd <= 1'b1;
        @(posedge clk_i);
        sw_rd <= 1'b0;
    endtask
    task automatic dev_wr(input logic [6:0] idx, input logic [31:0] d);
        sw_wr_t(HREG_RDATA, d);
        sw_wr_t(HREG_RADDR, (32'h1 << RADDR_WR_BIT) | {25'h0, idx});
        repeat (4) @(posedge clk_i);
    endtask
    task automatic frame(input bit is_pop, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            push <= !is_pop;
            pop <= is_pop;
            push_last <= !is_pop && i == n - 1;
            pop_last <= is_pop && i == n - 1;
        end
        @(posedge clk_i);
        {push, pop, push_last, pop_last} <= 4'h0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic tx_state(input logic [31:0] frames, input logic [31:0] fill);
        dev_rd(REG_TFC, frames);
        dev_rd(REG_TXFILL, fill);
    endtask
    task automatic resize(input logic [11:0] sz);
        int t;
        sw_wr_t(HREG_CTRL, (32'h1 << CTRL_GO_BIT) | {20'h0, sz});
        t = 0;
        while (halt !== 1'b1 && t < 20) begin
            @(posedge clk_i);
            t++;
        end
        check({31'h0, halt}, 32'h1);
        while (halt !== 1'b0 && t < 300) begin
            @(posedge clk_i);
            t++;
        end
        check({31'h0, halt}, 32'h0);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        check({20'h0, hi_sz, lo_sz, htx_sz}, {20'h0, SIZE_RESET});
        dev_rd(REG_SIZE, 32'h464);
        dev_rd(REG_OVF, 32'h0);
        dev_rd(7'h50, 32'h0);
        dev_rd(REG_CLEAR, 32'h0);
        // reserved codes and an oversize total are refused without a sequence
        foreach (bad[i]) begin
            sw_wr_t(HREG_CTRL, (32'h1 << CTRL_GO_BIT) | {20'h0, bad[i]});
            repeat (4) @(posedge clk_i);
            check({31'h0, halt}, 32'h0);
            exp_q.push_back(32'h2);
            @(posedge clk_i);
            sw_addr <= HREG_STAT;
            sw_rd <= 1'b1;
            @(posedge clk_i);
            sw_rd <= 1'b0;
        end
        resize(12'h061);
        check({31'h0, hi_ok}, 32'h0);
        dev_rd(REG_SIZE, 32'h061);
        check({20'h0, hi_sz, lo_sz, htx_sz}, 32'h061);
        seed = xs(seed);
        dev_wr(REG_INJ, seed);
        dev_rd(REG_INJ, {31'h0, seed[0]});
        // capacity is 1024 half-words at tx code 1: fill exactly, then overflow
        dev_wr(REG_IRQ_MASK, 32'h0);
        frame(1'b0, 3);
        tx_state(32'h1, 32'h3);
        frame(1'b0, 1021);
        tx_state(32'h2, 32'h400);
        frame(1'b0, 2);
        tx_state(32'h2, 32'h400);
        dev_wr(REG_OVF, 32'hFFFF);
        dev_rd(REG_OVF, 32'h1);
        check({31'h0, irq}, 32'h1);
        dev_rd(REG_IRQ_STAT, 32'h1);
        dev_wr(REG_IRQ_MASK, 32'h1);
        check({31'h0, irq}, 32'h0);
        dev_wr(REG_IRQ_MASK, 32'h0);
        check({31'h0, irq}, 32'h1);
        dev_wr(REG_IRQ_STAT, 32'h1);
        check({31'h0, irq}, 32'h0);
        frame(1'b1, 3);
        tx_state(32'h1, 32'h3FD);
        // flush during a transmission aborts it once
        check(32'(aborts), 32'h0);
        busy <= 1'b1;
        dev_wr(REG_CLEAR, 32'h2);
        check(32'(aborts), 32'h1);
        busy <= 1'b0;
        tx_state(32'h0, 32'h0);
        dev_wr(REG_CLEAR, 32'h1);
        check({31'h0, store_en}, 32'h0);
        @(posedge clk_i);
        rx_start <= 1'b1;
        @(posedge clk_i);
        rx_start <= 1'b0;
        repeat (2) @(posedge clk_i);
        check({31'h0, store_en}, 32'h1);
        seed = xs(seed);
        @(posedge clk_i);
        ecc_det <= 1'b1;
        ecc_addr <= seed[13:0];
        @(posedge clk_i);
        ecc_det <= 1'b0;
        dev_rd(REG_ECCADDR, {18'h0, seed[13:0]});
        dev_rd(REG_IRQ_STAT, 32'h2);
        // queue f gets f+1 repairs so a swapped index shows up
        for (int f = 0; f < CECC_NUM; f++) begin
            repeat (f + 1) begin
                @(posedge clk_i);
                ecc_corr <= 1'b1;
                ecc_fifo <= 3'(f);
            end
            @(posedge clk_i);
            ecc_corr <= 1'b0;
        end
        for (int f = 0; f < CECC_NUM; f++) dev_rd(REG_CECC0 + 7'(f), 32'(f + 1));
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        dev_rd(REG_SIZE, 32'h464);
        tx_state(32'h0, 32'h0);
        repeat (3) @(posedge clk_i);
        results();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        failures++;
        results();
    end
endmodule
`default_nettype wire
